// [common/div_if.sv]
// Divide operands and error flag between core and divide checker
`timescale 1ns/1ps
`default_nettype none
interface div_if;
  logic [31:0] dividend;
  logic [31:0] divisor;
  logic        is_signed;
  logic        err;
  modport chk (input dividend, input divisor, input is_signed, output err);
  modport src (output dividend, output divisor, output is_signed, input err);
endinterface
`default_nettype wire

// [common/exc_pkg.sv]
// Constants and types shared by the exception checking block
package exc_pkg;
  localparam int DATA_W = 32;
  localparam int CAUSE_W = 5;
  localparam int OP_W = 6;
  localparam int SYND_W = 6;

  // Cause codes written to the cause field
  localparam logic [4:0] CAUSE_ILLEGAL = 5'h05;
  localparam logic [4:0] CAUSE_MIS_DATA = 5'h06;
  localparam logic [4:0] CAUSE_MIS_DEST = 5'h07;
  localparam logic [4:0] CAUSE_DIV = 5'h08;
  localparam logic [4:0] CAUSE_RESET = 5'h00;

  localparam logic [31:0] ADDR_RESET = 32'h00000000;
  localparam logic [31:0] CPUID_AUTO = 32'h00000000;
  localparam logic [31:0] MOST_NEG = 32'h80000000;
  localparam logic [31:0] MINUS_ONE = 32'hFFFFFFFF;

  // Opcode that escapes to the extension field, and the defined-code masks
  localparam logic [5:0] RTYPE_OPCODE = 6'h3A;
  localparam logic [63:0] OP_DEFINED = 64'h7BFF_FFFF_FFFF_FFFF;
  localparam logic [63:0] OPX_DEFINED = 64'h3FFF_FFFF_FFFF_FFFE;

  // Configuration limits
  localparam int SHADOW_MAX = 63;
  localparam int REGIONS_MIN = 2;
  localparam int REGIONS_MAX = 32;
  localparam int REGION_LOG2_MIN = 6;
  localparam int REGION_LOG2_MAX = 20;

  typedef enum logic [2:0] {
    K_OTHER, K_LOAD, K_STORE, K_DIV, K_XFER
  } kind_type;

  typedef enum logic [1:0] {
    W_BYTE, W_HALF, W_WORD
  } width_type;
endpackage

// [design/div_check.sv]
// Divide result representability check
`timescale 1ns/1ps
`default_nettype none
module div_check (
  div_if.chk dv
);
  logic zero_div;
  logic overflow;

  assign zero_div = (dv.divisor == 32'h00000000); // RULE_03
  // Only the one signed pair overflows; unsigned never does
  assign overflow = dv.is_signed && (dv.dividend == exc_pkg::MOST_NEG)
                    && (dv.divisor == exc_pkg::MINUS_ONE); // RULE_04
  assign dv.err = zero_div || overflow; // RULE_04
endmodule // div_check
`default_nettype wire

// [design/exception_checker.sv]
// Exception detection, cause and address capture, and core option decode
`timescale 1ns/1ps
`default_nettype none
// How it works
// RULE_01: Undefined opcode raises illegal-instruction exception
// RULE_02: MMU or MPU forces illegal-instruction checking
// RULE_03: Zero divisor raises division error when enabled
// RULE_04: Most negative divided by minus one errors
// RULE_05: Misaligned word or half load/store faults
// RULE_06: Misaligned control transfer target raises exception
// RULE_07: MMU or MPU forces both misalignment checks
// RULE_08: Non-break exceptions write cause code field
// RULE_09: MMU or MPU forces cause recording
// RULE_10: Address-bearing exceptions capture faulting address
// RULE_11: Identifier fixed; reads zero unless assigned
// RULE_12: Internal or external interrupt controller selectable
// RULE_13: Zero to 63 shadow register sets
// RULE_14: Compatibility option suppresses memory initial contents
// RULE_15: ECC corrects single, detects double errors
// RULE_16: Detect-only ECC catches up to three
// RULE_17: MMU tag width and TLB sizes configurable
// RULE_18: Region extent by limit or size
// RULE_19: Data and instruction regions 2 to 32
// RULE_20: Minimum region size 64 B to 1 MB
// RULE_21: Maximum region size equals address span
// RULE_22: Unconfigured checks never raise exceptions
module exception_checker #(
  parameter bit          ILLEGAL_CHECK  = 1'b1,
  parameter bit          DIV_CHECK      = 1'b1,
  parameter bit          HW_DIVIDE      = 1'b1,
  parameter bit          MISALIGN_CHECK = 1'b1,
  parameter bit          EXTRA_INFO     = 1'b1,
  parameter bit          MMU_PRESENT    = 1'b0,
  parameter bit          MPU_PRESENT    = 1'b0,
  parameter bit          FAST_CORE      = 1'b1,
  parameter bit          CPUID_MANUAL   = 1'b0,
  parameter logic [31:0] CPUID_VALUE    = 32'h00000000,
  parameter bit          EIC_SELECT     = 1'b0,
  parameter int          SHADOW_SETS    = 0,
  parameter bit          ASIC_COMPAT    = 1'b0,
  parameter bit          ECC_PRESENT    = 1'b1,
  parameter bit          ECC_CORRECT    = 1'b1,
  parameter int          TAG_BITS       = 8,
  parameter int          TLB_ENTRIES    = 128,
  parameter int          TLB_WAYS       = 16,
  parameter int          UDTLB_ENTRIES  = 6,
  parameter int          UITLB_ENTRIES  = 4,
  parameter bit          REGION_BY_LIMIT = 1'b0,
  parameter int          DATA_REGIONS   = 8,
  parameter int          INST_REGIONS   = 8,
  parameter int          DREGION_LOG2   = 12,
  parameter int          IREGION_LOG2   = 12,
  parameter int          DATA_SPAN_LOG2 = 32,
  parameter int          INST_SPAN_LOG2 = 32
) (
  input  wire logic        CLOCK,
  input  wire logic        ARST_N,
  input  wire logic        ISSUE_VALID,
  input  wire logic [2:0]  ISSUE_KIND,
  input  wire logic [1:0]  ISSUE_WIDTH,
  input  wire logic        ISSUE_BREAK,
  input  wire logic        ISSUE_SIGNED,
  input  wire logic [5:0]  ISSUE_OPCODE,
  input  wire logic [5:0]  ISSUE_OPX,
  input  wire logic [31:0] ISSUE_ADDR,
  input  wire logic [31:0] ISSUE_DIVIDEND,
  input  wire logic [31:0] ISSUE_DIVISOR,
  input  wire logic [5:0]  ECC_SYNDROME,
  input  wire logic        ECC_PARITY,
  input  wire logic        ECC_CHECK,
  output logic             EXC_RAISE,
  output logic [4:0]       EXC_CAUSE,
  output logic [31:0]      EXC_BADADDR,
  output logic             EXC_BADADDR_LOAD,
  output logic             ECC_CORRECTED,
  output logic             ECC_FATAL,
  output logic [31:0]      CPUID,
  output logic             EXTERNAL_INTERRUPT_CONTROLLER_PORT,
  output logic [5:0]       SHADOW_SET_COUNT,
  output logic             MEM_PREINIT,
  output logic [5:0]       PROCESS_TAG_BITS,
  output logic [15:0]      TLB_ENTRY_COUNT,
  output logic [7:0]       TLB_WAY_COUNT,
  output logic [7:0]       UDTLB_ENTRY_COUNT,
  output logic [7:0]       UITLB_ENTRY_COUNT,
  output logic             REGION_LIMIT_MODE,
  output logic [5:0]       DATA_REGION_COUNT,
  output logic [5:0]       INST_REGION_COUNT,
  output logic [4:0]       DREGION_MIN_LOG2,
  output logic [4:0]       IREGION_MIN_LOG2,
  output logic [5:0]       DREGION_MAX_LOG2,
  output logic [5:0]       IREGION_MAX_LOG2
);
  // Effective enables; a memory manager or protector forces three of them
  localparam bit MEMPROT = MMU_PRESENT || MPU_PRESENT;
  localparam bit ILL_EN  = ILLEGAL_CHECK || MEMPROT; // RULE_02
  localparam bit DIV_EN  = DIV_CHECK && HW_DIVIDE && FAST_CORE; // RULE_03
  localparam bit MIS_EN  = MISALIGN_CHECK || MEMPROT; // RULE_07
  localparam bit INFO_EN = EXTRA_INFO || MEMPROT; // RULE_09

  logic       undefined;
  logic       hit_ill;
  logic       hit_div;
  logic       hit_mdata;
  logic       hit_mdest;
  logic       raise_nxt;
  logic [4:0] cause_nxt;
  logic       addr_nxt;
  logic       raise_r;
  logic [4:0] cause_r;
  logic [31:0] badaddr_r;
  logic       badaddr_load_r;
  logic       ecc_corr_r;
  logic       ecc_fatal_r;
  logic       ecc_corr_nxt;
  logic       ecc_fatal_nxt;

  div_if dv ();

  assign dv.dividend  = ISSUE_DIVIDEND;
  assign dv.divisor   = ISSUE_DIVISOR;
  assign dv.is_signed = ISSUE_SIGNED;

  div_check u_div (
    .dv (dv.chk)
  );

  // Extension field is decoded only under the escape opcode
  assign undefined = (ISSUE_OPCODE == exc_pkg::RTYPE_OPCODE) ?
                     !exc_pkg::OPX_DEFINED[ISSUE_OPX] :
                     !exc_pkg::OP_DEFINED[ISSUE_OPCODE]; // RULE_01

  // Disabled checks drop out here, so the operation proceeds silently
  assign hit_ill = ILL_EN && undefined; // RULE_01 RULE_22
  assign hit_div = DIV_EN && (ISSUE_KIND == exc_pkg::K_DIV)
                   && dv.err; // RULE_03 RULE_22
  assign hit_mdata = MIS_EN
                     && ((ISSUE_KIND == exc_pkg::K_LOAD)
                         || (ISSUE_KIND == exc_pkg::K_STORE))
                     && (((ISSUE_WIDTH == exc_pkg::W_WORD)
                          && (ISSUE_ADDR[1:0] != 2'b00))
                         || ((ISSUE_WIDTH == exc_pkg::W_HALF)
                             && ISSUE_ADDR[0])); // RULE_05 RULE_22
  assign hit_mdest = MIS_EN && (ISSUE_KIND == exc_pkg::K_XFER)
                     && (ISSUE_ADDR[1:0] != 2'b00); // RULE_06 RULE_22

  assign raise_nxt = ISSUE_VALID
                     && (ISSUE_BREAK || hit_ill || hit_div
                         || hit_mdata || hit_mdest);

  // Fixed priority: decode faults precede execute and address faults
  always_comb begin
    cause_nxt = exc_pkg::CAUSE_ILLEGAL;
    addr_nxt  = 1'b0;
    if (hit_ill) begin
      cause_nxt = exc_pkg::CAUSE_ILLEGAL;
    end else if (hit_div) begin
      cause_nxt = exc_pkg::CAUSE_DIV;
    end else if (hit_mdata) begin
      cause_nxt = exc_pkg::CAUSE_MIS_DATA;
      addr_nxt  = 1'b1;
    end else if (hit_mdest) begin
      cause_nxt = exc_pkg::CAUSE_MIS_DEST;
      addr_nxt  = 1'b1;
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      raise_r <= 1'b0;
    end else begin
      raise_r <= raise_nxt;
    end
  end

  // Breakpoints leave the cause field untouched
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      cause_r <= exc_pkg::CAUSE_RESET;
    end else if (raise_nxt && !ISSUE_BREAK && INFO_EN) begin
      cause_r <= cause_nxt; // RULE_08
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      badaddr_r      <= exc_pkg::ADDR_RESET;
      badaddr_load_r <= 1'b0;
    end else begin
      badaddr_load_r <= raise_nxt && !ISSUE_BREAK && addr_nxt;
      if (raise_nxt && !ISSUE_BREAK && addr_nxt) begin
        badaddr_r <= ISSUE_ADDR; // RULE_10
      end
    end
  end

  // Overall parity odd means an odd bit count; syndrome alone means even
  always_comb begin
    ecc_corr_nxt  = 1'b0;
    ecc_fatal_nxt = 1'b0;
    if (ECC_PRESENT && ECC_CHECK) begin
      if (ECC_CORRECT) begin
        ecc_corr_nxt  = ECC_PARITY; // RULE_15
        ecc_fatal_nxt = !ECC_PARITY && (ECC_SYNDROME != 6'h00); // RULE_15
      end else begin
        ecc_fatal_nxt = ECC_PARITY || (ECC_SYNDROME != 6'h00); // RULE_16
      end
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      ecc_corr_r  <= 1'b0;
      ecc_fatal_r <= 1'b0;
    end else begin
      ecc_corr_r  <= ecc_corr_nxt;
      ecc_fatal_r <= ecc_fatal_nxt;
    end
  end

  assign EXC_RAISE        = raise_r;
  assign EXC_CAUSE        = cause_r;
  assign EXC_BADADDR      = badaddr_r;
  assign EXC_BADADDR_LOAD = badaddr_load_r;
  assign ECC_CORRECTED    = ecc_corr_r;
  assign ECC_FATAL        = ecc_fatal_r;

  // Build-time options; shadow set, region count and minimum region size settings are clamped, tag, TLB, region mode and span settings pass through
  assign CPUID = CPUID_MANUAL ? CPUID_VALUE : exc_pkg::CPUID_AUTO; // RULE_11
  assign EXTERNAL_INTERRUPT_CONTROLLER_PORT = EIC_SELECT && FAST_CORE; // RULE_12
  assign SHADOW_SET_COUNT = (!FAST_CORE) ? 6'h00 :
    6'((SHADOW_SETS > exc_pkg::SHADOW_MAX) ? exc_pkg::SHADOW_MAX
       : ((SHADOW_SETS < 0) ? 0 : SHADOW_SETS)); // RULE_13
  assign MEM_PREINIT = !ASIC_COMPAT; // RULE_14
  assign PROCESS_TAG_BITS  = 6'(TAG_BITS); // RULE_17
  assign TLB_ENTRY_COUNT   = 16'(TLB_ENTRIES); // RULE_17
  assign TLB_WAY_COUNT     = 8'(TLB_WAYS); // RULE_17
  assign UDTLB_ENTRY_COUNT = 8'(UDTLB_ENTRIES); // RULE_17
  assign UITLB_ENTRY_COUNT = 8'(UITLB_ENTRIES); // RULE_17
  assign REGION_LIMIT_MODE = REGION_BY_LIMIT; // RULE_18
  assign DATA_REGION_COUNT = 6'((DATA_REGIONS < exc_pkg::REGIONS_MIN) ?
    exc_pkg::REGIONS_MIN : ((DATA_REGIONS > exc_pkg::REGIONS_MAX) ?
    exc_pkg::REGIONS_MAX : DATA_REGIONS)); // RULE_19
  assign INST_REGION_COUNT = 6'((INST_REGIONS < exc_pkg::REGIONS_MIN) ?
    exc_pkg::REGIONS_MIN : ((INST_REGIONS > exc_pkg::REGIONS_MAX) ?
    exc_pkg::REGIONS_MAX : INST_REGIONS)); // RULE_19
  assign DREGION_MIN_LOG2 = 5'((DREGION_LOG2 < exc_pkg::REGION_LOG2_MIN) ?
    exc_pkg::REGION_LOG2_MIN : ((DREGION_LOG2 > exc_pkg::REGION_LOG2_MAX) ?
    exc_pkg::REGION_LOG2_MAX : DREGION_LOG2)); // RULE_20
  assign IREGION_MIN_LOG2 = 5'((IREGION_LOG2 < exc_pkg::REGION_LOG2_MIN) ?
    exc_pkg::REGION_LOG2_MIN : ((IREGION_LOG2 > exc_pkg::REGION_LOG2_MAX) ?
    exc_pkg::REGION_LOG2_MAX : IREGION_LOG2)); // RULE_20
  assign DREGION_MAX_LOG2 = 6'(DATA_SPAN_LOG2); // RULE_21
  assign IREGION_MAX_LOG2 = 6'(INST_SPAN_LOG2); // RULE_21

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!ARST_N);

  property p_illegal;
    ISSUE_VALID && !ISSUE_BREAK && undefined && ILL_EN
      |=> EXC_RAISE && (!INFO_EN || EXC_CAUSE == exc_pkg::CAUSE_ILLEGAL);
  endproperty
  a_illegal: assert property (p_illegal) else $error("illegal op missed"); // RULE_01

  property p_forced;
    ISSUE_VALID && undefined && MEMPROT |=> EXC_RAISE;
  endproperty
  a_forced: assert property (p_forced) else $error("forced check missed"); // RULE_02

  property p_div;
    ISSUE_VALID && !ISSUE_BREAK && !undefined && DIV_EN && ISSUE_KIND == exc_pkg::K_DIV
      && ISSUE_DIVISOR == 32'h00000000
      |=> EXC_RAISE && (!INFO_EN || EXC_CAUSE == exc_pkg::CAUSE_DIV);
  endproperty
  a_div: assert property (p_div) else $error("zero divide missed"); // RULE_03

  property p_overflow;
    ISSUE_SIGNED && ISSUE_DIVIDEND == exc_pkg::MOST_NEG
      && ISSUE_DIVISOR == exc_pkg::MINUS_ONE |-> dv.err;
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow missed"); // RULE_04

  property p_misdata;
    ISSUE_VALID && !ISSUE_BREAK && !undefined && MIS_EN && ISSUE_KIND == exc_pkg::K_LOAD
      && ISSUE_WIDTH == exc_pkg::W_WORD && ISSUE_ADDR[1:0] != 2'b00
      |=> EXC_RAISE && EXC_BADADDR == $past(ISSUE_ADDR);
  endproperty
  a_misdata: assert property (p_misdata) else $error("misaligned data"); // RULE_05

  property p_byte_ok;
    ISSUE_VALID && !undefined && !ISSUE_BREAK
      && ISSUE_KIND == exc_pkg::K_STORE && ISSUE_WIDTH == exc_pkg::W_BYTE
      |=> !EXC_RAISE;
  endproperty
  a_byte_ok: assert property (p_byte_ok) else $error("byte access fault"); // RULE_05

  property p_misdest;
    ISSUE_VALID && !ISSUE_BREAK && !undefined && MIS_EN && ISSUE_KIND == exc_pkg::K_XFER
      && ISSUE_ADDR[0] |=> EXC_RAISE && EXC_BADADDR_LOAD;
  endproperty
  a_misdest: assert property (p_misdest) else $error("misaligned target"); // RULE_06

  property p_break_cause;
    ISSUE_VALID && ISSUE_BREAK |=> EXC_RAISE && $stable(EXC_CAUSE);
  endproperty
  a_break_cause: assert property (p_break_cause) else $error("break wrote cause"); // RULE_08

  property p_silent;
    ISSUE_VALID && !undefined && !ISSUE_BREAK && ISSUE_KIND == exc_pkg::K_OTHER
      |=> !EXC_RAISE;
  endproperty
  a_silent: assert property (p_silent) else $error("disabled check fired"); // RULE_22

  property p_ecc_double;
    ECC_PRESENT && ECC_CORRECT && ECC_CHECK && !ECC_PARITY
      && ECC_SYNDROME != 6'h00 |=> ECC_FATAL && !ECC_CORRECTED;
  endproperty
  a_ecc_double: assert property (p_ecc_double) else $error("double not flagged"); // RULE_15

  c_div: cover property (ISSUE_VALID && hit_div ##1 EXC_RAISE);
  c_mdata: cover property (ISSUE_VALID && hit_mdata ##1 EXC_BADADDR_LOAD);
  c_break: cover property (ISSUE_VALID && ISSUE_BREAK ##1 EXC_RAISE);
  c_ecc: cover property (ECC_CORRECTED);
endmodule // exception_checker
`default_nettype wire

// [dv/soft_cpu_exception_checking_tb.sv]
// Self-checking bench for the exception checking block and its option outputs
`timescale 1ns/1ps
`default_nettype none
module soft_cpu_exception_checking_tb;
  logic        CLOCK = 1'h0;
  logic        ARST_N = 1'h0;
  logic        vld = 1'h0, brk = 1'h0, sgn = 1'h0, ecc_chk = 1'h0, ecc_par = 1'h0;
  logic [2:0]  kind = 3'h0;
  logic [1:0]  wid = 2'h0;
  logic [5:0]  opc = 6'h04, ox = 6'h00, syn = 6'h00;
  logic [31:0] addr = 32'h0, dvd = 32'h0, dvs = 32'h1;
  logic        raise[2], ld[2], corr[2], fat[2], pre[2], eicp[2], lim[2];
  logic [4:0]  cause[2], dmin[2], imin[2];
  logic [31:0] bad[2], cpuid[2];
  logic [5:0]  shd[2], tagb[2], dcnt[2], icnt[2], dmax[2], imax[2];
  logic [15:0] tlb[2];
  logic [7:0]  ways[2], udt[2], uit[2];
  logic [4:0]  ecause[2] = '{5'h00, 5'h00};
  logic [31:0] ebad[2] = '{32'h0, 32'h0};
  int          err_count = 0;
  int          tests_run = 0;

  always #4 CLOCK = ~CLOCK;

  // Checks switched on by option
  exception_checker uut (
    .CLOCK(CLOCK), .ARST_N(ARST_N), .ISSUE_VALID(vld), .ISSUE_KIND(kind), .ISSUE_WIDTH(wid),
    .ISSUE_BREAK(brk), .ISSUE_SIGNED(sgn), .ISSUE_OPCODE(opc), .ISSUE_OPX(ox),
    .ISSUE_ADDR(addr), .ISSUE_DIVIDEND(dvd), .ISSUE_DIVISOR(dvs), .ECC_SYNDROME(syn),
    .ECC_PARITY(ecc_par), .ECC_CHECK(ecc_chk), .EXC_RAISE(raise[0]), .EXC_CAUSE(cause[0]),
    .EXC_BADADDR(bad[0]), .EXC_BADADDR_LOAD(ld[0]), .ECC_CORRECTED(corr[0]),
    .ECC_FATAL(fat[0]), .CPUID(cpuid[0]), .EXTERNAL_INTERRUPT_CONTROLLER_PORT(eicp[0]),
    .SHADOW_SET_COUNT(shd[0]), .MEM_PREINIT(pre[0]), .PROCESS_TAG_BITS(tagb[0]),
    .TLB_ENTRY_COUNT(tlb[0]), .TLB_WAY_COUNT(ways[0]), .UDTLB_ENTRY_COUNT(udt[0]),
    .UITLB_ENTRY_COUNT(uit[0]), .REGION_LIMIT_MODE(lim[0]), .DATA_REGION_COUNT(dcnt[0]),
    .INST_REGION_COUNT(icnt[0]), .DREGION_MIN_LOG2(dmin[0]), .IREGION_MIN_LOG2(imin[0]),
    .DREGION_MAX_LOG2(dmax[0]), .IREGION_MAX_LOG2(imax[0]));

  // Option bits off with a protector present, which forces those checks back on; ECC detect-only
  exception_checker #(
    .ILLEGAL_CHECK(1'h0), .MISALIGN_CHECK(1'h0), .EXTRA_INFO(1'h0), .MPU_PRESENT(1'h1),
    .ECC_CORRECT(1'h0)
  ) uut_mpu (
    .CLOCK(CLOCK), .ARST_N(ARST_N), .ISSUE_VALID(vld), .ISSUE_KIND(kind), .ISSUE_WIDTH(wid),
    .ISSUE_BREAK(brk), .ISSUE_SIGNED(sgn), .ISSUE_OPCODE(opc), .ISSUE_OPX(ox),
    .ISSUE_ADDR(addr), .ISSUE_DIVIDEND(dvd), .ISSUE_DIVISOR(dvs), .ECC_SYNDROME(syn),
    .ECC_PARITY(ecc_par), .ECC_CHECK(ecc_chk), .EXC_RAISE(raise[1]), .EXC_CAUSE(cause[1]),
    .EXC_BADADDR(bad[1]), .EXC_BADADDR_LOAD(ld[1]), .ECC_CORRECTED(corr[1]),
    .ECC_FATAL(fat[1]), .CPUID(cpuid[1]), .EXTERNAL_INTERRUPT_CONTROLLER_PORT(eicp[1]),
    .SHADOW_SET_COUNT(shd[1]), .MEM_PREINIT(pre[1]), .PROCESS_TAG_BITS(tagb[1]),
    .TLB_ENTRY_COUNT(tlb[1]), .TLB_WAY_COUNT(ways[1]), .UDTLB_ENTRY_COUNT(udt[1]),
    .UITLB_ENTRY_COUNT(uit[1]), .REGION_LIMIT_MODE(lim[1]), .DATA_REGION_COUNT(dcnt[1]),
    .INST_REGION_COUNT(icnt[1]), .DREGION_MIN_LOG2(dmin[1]), .IREGION_MIN_LOG2(imin[1]),
    .DREGION_MAX_LOG2(dmax[1]), .IREGION_MAX_LOG2(imax[1]));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_of_test;
    if (err_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Expected cause of the instruction on the issue port, 0 when none; illegal has top priority
  function automatic logic [4:0] predict(input bit div_on);
    if (opc == 6'h3F || (opc == 6'h3A && (ox == 6'h00 || ox >= 6'h3E)))
      return exc_pkg::CAUSE_ILLEGAL;
    if (div_on && kind == exc_pkg::K_DIV && (dvs == 32'h0 ||
        (sgn && dvd == 32'h80000000 && dvs == 32'hFFFFFFFF)))
      return exc_pkg::CAUSE_DIV;
    if ((kind == exc_pkg::K_LOAD || kind == exc_pkg::K_STORE) &&
        ((wid == exc_pkg::W_WORD && addr[1:0] != 2'h0) || (wid == exc_pkg::W_HALF && addr[0])))
      return exc_pkg::CAUSE_MIS_DATA;
    if (kind == exc_pkg::K_XFER && addr[1:0] != 2'h0)
      return exc_pkg::CAUSE_MIS_DEST;
    return 5'h00;
  endfunction

  // One instruction per call; calls chain back to back with the valid held high
  task automatic issue(input logic [2:0] k, input logic [1:0] w, input logic [11:0] op,
                       input logic [31:0] a, input logic [31:0] dd, input logic [31:0] ds,
                       input logic s, input logic b);
    logic [4:0] c;
    {kind, wid, opc, ox, addr, dvd, dvs, sgn, brk, vld} = {k, w, op, a, dd, ds, s, b, 1'h1};
    @(posedge CLOCK);
    #1;
    for (int i = 0; i < 2; i++) begin
      c = b ? 5'h00 : predict(1'b1);
      if (c != 5'h00) ecause[i] = c;
      if (c == exc_pkg::CAUSE_MIS_DATA || c == exc_pkg::CAUSE_MIS_DEST) ebad[i] = a;
      chk("raise", 32'(raise[i]), 32'(b || c != 5'h00));
      chk("addr_load", 32'(ld[i]),
          32'(c == exc_pkg::CAUSE_MIS_DATA || c == exc_pkg::CAUSE_MIS_DEST));
      chk("cause", 32'(cause[i]), 32'(ecause[i]));
      chk("badaddr", bad[i], ebad[i]);
    end
  endtask

  task automatic ecc(input logic [5:0] sy, input logic p, input logic [3:0] e);
    {ecc_chk, syn, ecc_par} = {1'h1, sy, p};
    @(posedge CLOCK);
    #1;
    for (int i = 0; i < 2; i++) begin
      chk("corrected", 32'(corr[i]), 32'(e[3 - 2 * i]));
      chk("fatal", 32'(fat[i]), 32'(e[2 - 2 * i]));
    end
  endtask

  initial begin
    #20000;
    err_count++;
    end_of_test();
  end

  initial begin
    repeat (2) @(posedge CLOCK);
    #1;
    ARST_N = 1'h1;
    issue(exc_pkg::K_OTHER, exc_pkg::W_WORD, 12'h100, 32'h3, 32'h0, 32'h1, 1'h0, 1'h0);
    issue(exc_pkg::K_OTHER, exc_pkg::W_WORD, 12'hFC0, 32'h0, 32'h0, 32'h1, 1'h0, 1'h0);
    issue(exc_pkg::K_OTHER, exc_pkg::W_WORD, 12'hEBF, 32'h0, 32'h0, 32'h1, 1'h0, 1'h0);
    issue(exc_pkg::K_OTHER, exc_pkg::W_WORD, 12'hE81, 32'h0, 32'h0, 32'h1, 1'h0, 1'h0);
    issue(exc_pkg::K_DIV, exc_pkg::W_WORD, 12'h100, 32'h0, 32'h7, 32'h0, 1'h0, 1'h0);
    issue(exc_pkg::K_DIV, exc_pkg::W_WORD, 12'h100, 32'h0, 32'h80000000, 32'hFFFFFFFF,
          1'h1, 1'h0);
    issue(exc_pkg::K_DIV, exc_pkg::W_WORD, 12'h100, 32'h0, 32'h80000000, 32'hFFFFFFFF,
          1'h0, 1'h0);
    issue(exc_pkg::K_DIV, exc_pkg::W_WORD, 12'h100, 32'h0, 32'h80000000, 32'hFFFFFFFE,
          1'h1, 1'h0);
    for (int k = 1; k <= 2; k++)
      for (int w = 0; w <= 2; w++)
        for (int lo = 0; lo < 4; lo++)
          issue(3'(k), 2'(w), 12'h100, 32'hA5A55A50 + 32'(lo) + 32'(w * 16), 32'h0, 32'h1,
                1'h0, 1'h0);
    for (int lo = 0; lo < 4; lo++)
      issue(exc_pkg::K_XFER, exc_pkg::W_WORD, 12'h100, 32'h00008000 + 32'(lo), 32'h0, 32'h1,
            1'h0, 1'h0);
    issue(exc_pkg::K_OTHER, exc_pkg::W_WORD, 12'h100, 32'h0, 32'h0, 32'h1, 1'h0, 1'h1);
    issue(exc_pkg::K_LOAD, exc_pkg::W_WORD, 12'hFC0, 32'h2, 32'h0, 32'h1, 1'h0, 1'h0);
    vld = 1'h0;
    @(posedge CLOCK);
    #1;
    chk("raise_idle", 32'({raise[0], raise[1]}), 32'h0);
    ecc(6'h05, 1'h1, 4'h9);
    ecc(6'h05, 1'h0, 4'h5);
    ecc(6'h07, 1'h1, 4'h9);
    ecc(6'h00, 1'h0, 4'h0);
    ecc_chk = 1'h0;
    // Reset in mid-run must clear the held cause and address
    ARST_N = 1'h0;
    #2;
    for (int i = 0; i < 2; i++) begin
      chk("cause_rst", 32'(cause[i]), 32'h0);
      chk("badaddr_rst", bad[i], 32'h0);
      ecause[i] = 5'h00;
      ebad[i] = 32'h0;
    end
    @(posedge CLOCK);
    #1;
    ARST_N = 1'h1;
    issue(exc_pkg::K_STORE, exc_pkg::W_HALF, 12'h100, 32'h00000011, 32'h0, 32'h1,
          1'h0, 1'h0);
    vld = 1'h0;
    for (int i = 0; i < 2; i++) begin
      chk("cpuid", cpuid[i], 32'h0);
      chk("eic", 32'(eicp[i]), 32'h0);
      chk("shadow", 32'(shd[i]), 32'h0);
      chk("preinit", 32'(pre[i]), 32'h1);
      chk("tag_bits", 32'(tagb[i]), 32'h8);
      chk("tlb", 32'(tlb[i]), 32'h80);
      chk("ways", 32'(ways[i]), 32'h10);
      chk("udtlb", 32'(udt[i]), 32'h6);
      chk("uitlb", 32'(uit[i]), 32'h4);
      chk("limit", 32'(lim[i]), 32'h0);
      chk("dregions", 32'(dcnt[i]), 32'h8);
      chk("iregions", 32'(icnt[i]), 32'h8);
      chk("dmin", 32'(dmin[i]), 32'hC);
      chk("imin", 32'(imin[i]), 32'hC);
      chk("dmax", 32'(dmax[i]), 32'h20);
      chk("imax", 32'(imax[i]), 32'h20);
    end
    end_of_test();
  end
endmodule // soft_cpu_exception_checking_tb
`default_nettype wire
